/* sarc_pkg.sv */
// Operation
// - Input above high reference returns full scale, no overflow flag.
// - Input below low reference returns zero in both result bytes.
// - Setting converter_on enables and converts the channel continuously.
// - Clearing converter_on disables the converter and halts conversion.
// - Conversion end sets flag bit 7 and loads both result bytes.
// - Flag clears on high byte read or any control/status write.
// - Results are not latched; each new conversion overwrites both.
// - New input_select write aborts, clears flag, restarts conversion.
// - input_select is a plain binary index of inputs 0 to 15.
// - Bit 6 picks converter clock: 0 is divide by 4, 1 by 2.
// - Flag bit is read only; other control bits read and write.
// - High byte holds result 9:2; low byte holds 1:0, rest zero.
// - Wait mode has no effect; halt mode disables the converter.
// - Registers at 70h, 71h, 72h, all resetting to zero.
package sarc_pkg;
    // Register indices; byte address is four times the index
    localparam logic [7:0] IDX_CSR = 8'h70;
    localparam logic [7:0] IDX_HIGH = 8'h71;
    localparam logic [7:0] IDX_LOW = 8'h72;
    localparam logic [7:0] CSR_RST = 8'h00;
    localparam logic [9:0] RES_RST = 10'h000;
    // Field positions in converter_control_status
    localparam int EOC_BIT = 7;
    localparam int SPEED_BIT = 6;
    localparam int ON_BIT = 5;
    localparam int RSVD_BIT = 4;
    localparam int SEL_MSB = 3;
    // Result layout
    localparam int RES_BITS = 10;
    localparam logic [9:0] FULL_SCALE = 10'h3FF;
    localparam logic [9:0] ZERO_SCALE = 10'h000;
    localparam logic [9:0] SAR_FIRST = 10'h200;
    // Timing counts in converter ticks and cpu clocks
    localparam int SAMPLE_TICKS = 3;
    localparam logic [1:0] DIV_SLOW_LAST = 2'h3;
    localparam logic [1:0] DIV_FAST_LAST = 2'h1;
    typedef enum logic [1:0] {ST_IDLE, ST_SAMPLE, ST_CONVERT} sarc_state_t;
endpackage : sarc_pkg

/* sarc_clkdiv.sv */
`timescale 1ns/1ps
// Converter clock tick: one pulse every 2 or 4 cpu clocks
module sarc_clkdiv
(
    input wire logic clk_sys,
    input wire logic reset,
    input wire logic restart,
    input wire logic fast,
    output logic tick
);
    logic [1:0] cnt_r;
    logic [1:0] last;

    // Terminal count from the speed bit
    assign last = fast ? sarc_pkg::DIV_FAST_LAST : sarc_pkg::DIV_SLOW_LAST;
    assign tick = (cnt_r == last) && !restart;

    // Free counter, rewound on restart so ticks align with conversion start
    always_ff @(posedge clk_sys or posedge reset)
    begin
        if (reset)
            cnt_r <= 2'h0;
        else if (restart || cnt_r >= last)
            cnt_r <= 2'h0;
        else
            cnt_r <= cnt_r + 2'h1;
    end
endmodule : sarc_clkdiv

/* sarc_sar.sv */
`timescale 1ns/1ps
// Successive-approximation register: one trial bit per step
module sarc_sar
(
    input wire logic clk_sys,
    input wire logic reset,
    input wire logic start,
    input wire logic step,
    input wire logic keep,
    output logic [9:0] code,
    output logic done
);
    logic [9:0] code_r;
    logic [9:0] mask_r;
    logic [9:0] kept;

    // Drop the trial bit when the comparator says the input is lower
    assign kept = keep ? code_r : (code_r & ~mask_r);
    assign code = code_r;
    assign done = step && mask_r[0];

    // Start loads the mid-scale trial, each step moves one bit down
    always_ff @(posedge clk_sys or posedge reset)
    begin
        if (reset)
        begin
            code_r <= 10'h000;
            mask_r <= 10'h000;
        end
        else if (start)
        begin
            code_r <= sarc_pkg::SAR_FIRST;
            mask_r <= sarc_pkg::SAR_FIRST;
        end
        else if (step && mask_r != 10'h000)
        begin
            code_r <= kept | (mask_r >> 1);
            mask_r <= mask_r >> 1;
        end
    end
endmodule : sarc_sar

/* sarc_top.sv */
`timescale 1ns/1ps
// Control logic of a 10-bit successive-approximation converter
module sarc_top
(
    input wire logic clk_sys,
    input wire logic reset,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic halt_mode,
    input wire logic ana_cmp_above,
    input wire logic ana_over_high,
    input wire logic ana_under_low,
    output logic ana_power,
    output logic [3:0] ana_channel,
    output logic ana_sample,
    output logic [9:0] ana_dac_code
);
    sarc_pkg::sarc_state_t state_r;
    sarc_pkg::sarc_state_t state_nxt;
    logic speed_r;
    logic on_r;
    logic [3:0] sel_r;
    logic eoc_r;
    logic eoc_nxt;
    logic [9:0] result_r;
    logic [9:0] result_nxt;
    logic [31:0] prdata_r;
    logic [1:0] cnt_r;
    logic [1:0] cnt_nxt;
    logic phase_r;
    logic [2:0] sync1_r;
    logic [2:0] sync2_r;

    // Register decode
    function automatic logic hit(input logic [11:0] a, input logic [7:0] idx);
        hit = (a[11:2] == {2'h0, idx}) && (a[1:0] == 2'h0);
    endfunction : hit

    logic sel_csr;
    logic sel_high;
    logic sel_low;
    logic mapped;
    logic acc;
    logic wr_csr;
    logic rd_high;
    logic rd_setup;
    logic sel_change;
    logic run;
    logic restart;
    logic tick;
    logic sar_start;
    logic sar_step;
    logic sar_done;
    logic [9:0] sar_code;
    logic cmp_s;
    logic over_s;
    logic under_s;
    logic [7:0] csr_view;
    logic [7:0] rd_byte;

    assign sel_csr = hit(paddr, sarc_pkg::IDX_CSR);
    assign sel_high = hit(paddr, sarc_pkg::IDX_HIGH);
    assign sel_low = hit(paddr, sarc_pkg::IDX_LOW);
    assign mapped = sel_csr || sel_high || sel_low;
    assign acc = psel && penable;
    assign wr_csr = acc && pwrite && sel_csr;
    assign rd_high = acc && !pwrite && sel_high;
    assign rd_setup = psel && !penable && !pwrite;
    assign sel_change = wr_csr && (pwdata[sarc_pkg::SEL_MSB:0] != sel_r);

    // APB answers with no wait state; unmapped access gives an error
    assign pready = 1'b1;
    assign pslverr = acc && !mapped;
    assign prdata = prdata_r;

    // Read views: flag read only, reserved bit reads zero
    assign csr_view = {eoc_r, speed_r, on_r, 1'b0, sel_r};
    assign rd_byte = sel_csr ? csr_view :
                     sel_high ? result_r[9:2] :
                     sel_low ? {6'h00, result_r[1:0]} : 8'h00;

    // Read data captured in the setup cycle, held for the access cycle
    always_ff @(posedge clk_sys or posedge reset)
    begin
        if (reset)
            prdata_r <= 32'h00000000;
        else if (rd_setup)
            prdata_r <= {24'h000000, rd_byte};
    end

    // Control bits; the reserved bit is not stored
    always_ff @(posedge clk_sys or posedge reset)
    begin
        if (reset)
        begin
            speed_r <= sarc_pkg::CSR_RST[sarc_pkg::SPEED_BIT];
            on_r <= sarc_pkg::CSR_RST[sarc_pkg::ON_BIT];
            sel_r <= sarc_pkg::CSR_RST[sarc_pkg::SEL_MSB:0];
        end
        else if (wr_csr)
        begin
            speed_r <= pwdata[sarc_pkg::SPEED_BIT];
            on_r <= pwdata[sarc_pkg::ON_BIT];
            sel_r <= pwdata[sarc_pkg::SEL_MSB:0];
        end
    end

    // Comparator and range flags come from the analog core: two flops each
    always_ff @(posedge clk_sys or posedge reset)
    begin
        if (reset)
        begin
            sync1_r <= 3'h0;
            sync2_r <= 3'h0;
        end
        else
        begin
            sync1_r <= {ana_cmp_above, ana_over_high, ana_under_low};
            sync2_r <= sync1_r;
        end
    end

    assign cmp_s = sync2_r[2];
    assign over_s = sync2_r[1];
    assign under_s = sync2_r[0];

    // Converter runs only while on and not halted; wait mode is not seen here
    assign run = on_r && !halt_mode;
    assign restart = (state_r == sarc_pkg::ST_IDLE) || sel_change;
    assign ana_power = run;
    assign ana_channel = sel_r;
    assign ana_sample = (state_r == sarc_pkg::ST_SAMPLE);
    assign ana_dac_code = sar_code;

    sarc_clkdiv u_div
    (
        .clk_sys(clk_sys),
        .reset(reset),
        .restart(restart),
        .fast(speed_r),
        .tick(tick)
    );

    // Each SAR step spends one tick settling and one tick deciding
    assign sar_start = tick && (state_r == sarc_pkg::ST_SAMPLE)
                       && (cnt_r == 2'(sarc_pkg::SAMPLE_TICKS - 1));
    assign sar_step = tick && (state_r == sarc_pkg::ST_CONVERT) && phase_r && run
                      && !sel_change;

    sarc_sar u_sar
    (
        .clk_sys(clk_sys),
        .reset(reset),
        .start(sar_start),
        .step(sar_step),
        .keep(cmp_s),
        .code(sar_code),
        .done(sar_done)
    );

    // Sequencer next state
    always_comb
    begin
        state_nxt = state_r;
        cnt_nxt = cnt_r;
        case (state_r)
            sarc_pkg::ST_IDLE:
            begin
                cnt_nxt = 2'h0;
                if (run)
                    state_nxt = sarc_pkg::ST_SAMPLE;
            end
            sarc_pkg::ST_SAMPLE:
            begin
                if (tick)
                    cnt_nxt = cnt_r + 2'h1;
                if (sar_start)
                begin
                    state_nxt = sarc_pkg::ST_CONVERT;
                    cnt_nxt = 2'h0;
                end
            end
            sarc_pkg::ST_CONVERT:
            begin
                if (sar_done)
                    state_nxt = sarc_pkg::ST_SAMPLE;
            end
            default:
                state_nxt = sarc_pkg::ST_IDLE;
        endcase
        if (sel_change)
        begin
            state_nxt = sarc_pkg::ST_SAMPLE;
            cnt_nxt = 2'h0;
        end
        if (!run || (wr_csr && !pwdata[sarc_pkg::ON_BIT]))
        begin
            state_nxt = sarc_pkg::ST_IDLE;
            cnt_nxt = 2'h0;
        end
    end

    // Sequencer state, sample count and step phase
    always_ff @(posedge clk_sys or posedge reset)
    begin
        if (reset)
        begin
            state_r <= sarc_pkg::ST_IDLE;
            cnt_r <= 2'h0;
            phase_r <= 1'b0;
        end
        else
        begin
            state_r <= state_nxt;
            cnt_r <= cnt_nxt;
            // Phase starts at zero on entry so the first trial gets a full settling tick
            phase_r <= (state_r == sarc_pkg::ST_CONVERT && state_nxt == sarc_pkg::ST_CONVERT) ?
                       (phase_r ^ tick) : 1'b0;
        end
    end

    // Result with saturation; no overflow flag is kept
    assign result_nxt = over_s ? sarc_pkg::FULL_SCALE :
                        under_s ? sarc_pkg::ZERO_SCALE :
                        {sar_code[9:1], cmp_s}; // Last trial bit kept only if the comparator agrees

    // Every finished conversion overwrites the result, read or not
    always_ff @(posedge clk_sys or posedge reset)
    begin
        if (reset)
            result_r <= sarc_pkg::RES_RST;
        else if (sar_done)
            result_r <= result_nxt;
    end

    // End flag: set wins over clear; no interrupt line exists
    assign eoc_nxt = sar_done ? 1'b1 :
                     (rd_high || wr_csr) ? 1'b0 : eoc_r;
    // Completion is only reported through the polled flag
    always_ff @(posedge clk_sys or posedge reset)
    begin
        if (reset)
            eoc_r <= 1'b0;
        else
            eoc_r <= eoc_nxt;
    end

    // Checks
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (reset);

    a_eoc_after_done: assert property (sar_done |=> eoc_r)
        else $error("flag not set after conversion end");
    a_eoc_read_clear: assert property (rd_high && !sar_done |=> !eoc_r)
        else $error("flag not cleared by high byte read");
    a_eoc_write_clear: assert property (wr_csr && !sar_done |=> !eoc_r)
        else $error("flag not cleared by control write");
    a_over_full: assert property (sar_done && over_s |=> result_r == 10'h3FF)
        else $error("overrange not saturated to full scale");
    a_under_zero: assert property (sar_done && under_s && !over_s |=> result_r == 10'h000)
        else $error("underrange not forced to zero");
    a_off_idle: assert property (wr_csr && !pwdata[5] |=> state_r == sarc_pkg::ST_IDLE ##1 !sar_done)
        else $error("converter kept running after switch off");
    a_halt_stops: assert property (halt_mode |-> !ana_power ##1 (state_r == sarc_pkg::ST_IDLE))
        else $error("halt did not disable converter");
    a_sel_restart: assert property (sel_change && run && pwdata[sarc_pkg::ON_BIT]
        |=> state_r == sarc_pkg::ST_SAMPLE && !eoc_r)
        else $error("channel change did not restart");
    a_low_upper_zero: assert property (rd_setup && sel_low |=> prdata[31:2] == 30'h0)
        else $error("low byte upper bits not zero");
    a_high_bits: assert property (rd_setup && sel_high |=> prdata[7:0] == $past(result_r[9:2]))
        else $error("high byte does not show result 9:2");
    a_fast_tick: assert property (speed_r && tick ##1 (!restart && speed_r)
        |-> !tick ##1 (tick || restart || !speed_r))
        else $error("fast divider not two clocks");
    a_slow_tick: assert property (!speed_r && tick ##1 (!restart && !speed_r)[*4] |-> tick)
        else $error("slow divider not four clocks");

    // Trial steps since the last start, for the step-count check
    logic [3:0] steps_r;
    always_ff @(posedge clk_sys or posedge reset)
    begin
        if (reset)
            steps_r <= 4'h0;
        else if (sar_start)
            steps_r <= 4'h0;
        else if (sar_step && steps_r != 4'hF)
            steps_r <= steps_r + 4'h1;
    end

    // Converter ticks since the trial started, for the conversion-length check
    logic [4:0] conv_ticks_r;
    always_ff @(posedge clk_sys or posedge reset)
    begin
        if (reset)
            conv_ticks_r <= 5'h00;
        else if (sar_start)
            conv_ticks_r <= 5'h00;
        else if (tick && conv_ticks_r != 5'h1F)
            conv_ticks_r <= conv_ticks_r + 5'h01;
    end

    // Conversion length and result loading
    a_step_count: assert property (sar_done |-> steps_r == 4'h9)
        else $error("conversion did not take ten steps");
    a_conv_ticks: assert property (sar_done |-> conv_ticks_r == 5'h13)
        else $error("trial phase not twenty ticks");
    a_done_loads: assert property (sar_done && !over_s && !under_s
        |=> result_r[9:1] == $past(sar_code[9:1]))
        else $error("result not loaded from trial code");
    a_result_hold: assert property (!sar_done |=> result_r == $past(result_r))
        else $error("result changed without conversion end");
    a_eoc_only_done: assert property (!sar_done && !eoc_r |=> !eoc_r)
        else $error("flag set without conversion end");
    // Power and sequencing
    a_power_on: assert property (wr_csr && pwdata[sarc_pkg::ON_BIT] |=> ana_power || halt_mode)
        else $error("converter not powered after switch on");
    a_idle_leaves: assert property (state_r == sarc_pkg::ST_IDLE && run && !wr_csr
        |=> state_r == sarc_pkg::ST_SAMPLE)
        else $error("sequencer did not start sampling");
    a_off_power: assert property (!on_r |-> !ana_power)
        else $error("converter powered while switched off");
    a_halt_no_done: assert property (halt_mode |=> !sar_done)
        else $error("conversion ended during halt");
    a_chan_follow: assert property (wr_csr |=> ana_channel == $past(pwdata[3:0]))
        else $error("input index does not follow register");
    // Register views and bus answers
    a_csr_rsvd_zero: assert property (rd_setup && sel_csr |=> prdata[4] == 1'b0 && prdata[31:8] == 24'h000000)
        else $error("reserved control bits not zero");
    a_csr_ctrl: assert property (rd_setup && sel_csr |=> prdata[6:5] == $past({speed_r, on_r}))
        else $error("control bits not read back");
    a_eoc_view: assert property (rd_setup && sel_csr |=> prdata[7] == $past(eoc_r))
        else $error("flag not shown in bit 7");
    a_low_bits: assert property (rd_setup && sel_low |=> prdata[1:0] == $past(result_r[1:0]))
        else $error("low byte does not show result 1:0");
    a_unmapped_zero: assert property (rd_setup && !mapped |=> prdata == 32'h00000000)
        else $error("unmapped read not zero");
    a_mapped_ok: assert property (acc && mapped |-> !pslverr)
        else $error("error on mapped register");

    c_conversion: cover property (sar_done ##[1:100] rd_high);
    c_chan_change: cover property (state_r == sarc_pkg::ST_CONVERT && sel_change);
    c_saturate: cover property (sar_done && over_s);
    c_halt: cover property (state_r == sarc_pkg::ST_CONVERT && halt_mode);
    c_fast_done: cover property (sar_done && speed_r);
endmodule : sarc_top

/* sarc_analog_model.sv */
`timescale 1ns/1ps
// Stand-in for the analog core: per-input level, sample-and-hold, comparator
module sarc_analog_model
(
    input wire logic clk_sys,
    input wire logic ana_power,
    input wire logic [3:0] ana_channel,
    input wire logic ana_sample,
    input wire logic [9:0] ana_dac_code,
    output logic ana_cmp_above,
    output logic ana_over_high,
    output logic ana_under_low
);
    logic [9:0] level [16];
    logic [1:0] range [16];
    logic [9:0] held = 10'h000;
    logic junk = 1'b0;
    // Hold the selected input while sampling; toggling noise feeds unpowered outputs
    always @(posedge clk_sys)
    begin
        if (ana_sample)
            held <= level[ana_channel];
        junk <= ~junk;
    end
    // Comparator and out-of-range detectors, meaningless while unpowered
    assign ana_cmp_above = ana_power ? (held >= ana_dac_code) : junk;
    assign ana_over_high = ana_power ? (range[ana_channel] == 2'h1) : junk;
    assign ana_under_low = ana_power ? (range[ana_channel] == 2'h2) : ~junk;
endmodule : sarc_analog_model

/* sarc_top_bench.sv */
`timescale 1ns/1ps
// Self-checking bench for the converter control logic
module sarc_top_bench;
    typedef struct packed {logic [31:0] d; logic [31:0] m; logic e;} sarc_exp_t;
    localparam logic [11:0] A_CSR = {2'h0, sarc_pkg::IDX_CSR, 2'h0};
    localparam logic [11:0] A_HIGH = {2'h0, sarc_pkg::IDX_HIGH, 2'h0};
    localparam logic [11:0] A_LOW = {2'h0, sarc_pkg::IDX_LOW, 2'h0};
    logic clk_sys, reset, psel, penable, pwrite, pready, pslverr, halt_mode;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic cmp_above, over_high, under_low, ana_power, ana_sample;
    logic [3:0] ana_channel;
    logic [9:0] ana_dac_code, v;
    sarc_exp_t exp_q[$];
    int num_errors = 0;
    int check_count = 0;
    int cycles = 0;
    integer seed = 1538;
    sarc_top i_sarc_top (.clk_sys(clk_sys), .reset(reset), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .halt_mode(halt_mode), .ana_cmp_above(cmp_above),
        .ana_over_high(over_high), .ana_under_low(under_low), .ana_power(ana_power),
        .ana_channel(ana_channel), .ana_sample(ana_sample), .ana_dac_code(ana_dac_code));
    sarc_analog_model i_sarc_analog_model (.clk_sys(clk_sys), .ana_power(ana_power),
        .ana_channel(ana_channel), .ana_sample(ana_sample), .ana_dac_code(ana_dac_code),
        .ana_cmp_above(cmp_above), .ana_over_high(over_high), .ana_under_low(under_low));
    // Clock generator
    initial
    begin
        clk_sys = 1'b0;
        forever #50 clk_sys = ~clk_sys;
    end
    // Closing report
    task wrap_up;
        $display("checks %0d mismatches %0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : wrap_up
    // Compare one bus answer against the oldest note
    task check(input sarc_exp_t x);
        check_count++;
        if ((prdata & x.m) !== (x.d & x.m) || pslverr !== x.e)
        begin
            num_errors++;
            $display("BAD t=%0t got %h/%h exp %h/%h", $time, prdata, pslverr, x.d, x.e);
        end
    endtask : check
    // Monitor: each completed access takes one note off the queue
    always @(posedge clk_sys)
    begin
        if (psel && penable && pready === 1'b1 && exp_q.size() > 0)
            check(exp_q.pop_front());
    end
    // Hang guard
    always @(posedge clk_sys)
    begin
        cycles++;
        if (cycles == 60000)
        begin
            num_errors++;
            wrap_up();
        end
    end
    // One APB transfer; the expectation is noted as the access phase begins
    task apb(input logic w, input logic [11:0] a, input logic [31:0] wd, input sarc_exp_t x);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= wd;
        penable <= 1'b0;
        @(posedge clk_sys);
        penable <= 1'b1;
        exp_q.push_back(x);
        @(posedge clk_sys);
        while (pready !== 1'b1)
            @(posedge clk_sys);
        rd = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk_sys);
    endtask : apb
    task rd_reg(input logic [11:0] a, input logic [31:0] d, input logic [31:0] m);
        apb(1'b0, a, 32'h0, {d, m, 1'b0});
    endtask : rd_reg
    task wr_reg(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d, {32'h0, 32'h0, 1'b0});
    endtask : wr_reg
    // Poll the completion flag under a bounded count
    task wait_eoc;
        int n;
        n = 0;
        rd = 32'h0;
        while (rd[7] !== 1'b1 && n < 300)
        begin
            rd_reg(A_CSR, 32'h0, 32'h0);
            n++;
        end
        check_count++;
        if (rd[7] !== 1'b1)
        begin
            num_errors++;
            $display("BAD t=%0t got %h exp %h", $time, rd[7], 1'b1);
        end
    endtask : wait_eoc
    // Start a channel, poll, read low then high, confirm the flag has cleared
    task conv(input logic [3:0] ch, input logic sp, input logic [1:0] rg, input logic [9:0] val);
        logic [9:0] r;
        i_sarc_analog_model.level[ch] = val;
        i_sarc_analog_model.range[ch] = rg;
        r = (rg == 2'h1) ? sarc_pkg::FULL_SCALE : (rg == 2'h2) ? sarc_pkg::ZERO_SCALE : val;
        wr_reg(A_CSR, {24'h0, 1'b0, sp, 1'b1, 1'b0, ch});
        wait_eoc();
        rd_reg(A_LOW, {30'h0, r[1:0]}, 32'hFFFFFFFF);
        rd_reg(A_HIGH, {24'h0, r[9:2]}, 32'hFFFFFFFF);
        rd_reg(A_CSR, {24'h0, 1'b0, sp, 1'b1, 1'b0, ch}, 32'hFFFFFFFF);
    endtask : conv
    // Main sequence
    initial
    begin
        {psel, penable, pwrite, halt_mode} = 4'h0;
        paddr = 12'h000;
        pwdata = 32'h0;
        reset = 1'b1;
        repeat (16) @(posedge clk_sys);
        reset <= 1'b0;
        @(posedge clk_sys);
        rd_reg(A_CSR, 32'h0, 32'hFFFFFFFF);
        rd_reg(A_HIGH, 32'h0, 32'hFFFFFFFF);
        rd_reg(A_LOW, 32'h0, 32'hFFFFFFFF);
        wr_reg(A_CSR, 32'h000000C0);
        rd_reg(A_CSR, 32'h00000040, 32'hFFFFFFFF);
        apb(1'b0, 12'h1CC, 32'h0, {32'h0, 32'h0, 1'b1});
        apb(1'b1, 12'h1CC, 32'hFF, {32'h0, 32'h0, 1'b1});
        $display("test registers done");
        for (int ch = 0; ch < 16; ch++)
        begin
            v = 10'($random(seed));
            conv(4'(ch), ch[0], 2'h0, v);
        end
        conv(4'h3, 1'b1, 2'h1, 10'h155);
        conv(4'h5, 1'b0, 2'h2, 10'h2AA);
        $display("test channels done");
        // Switch input mid-conversion; the old input's value must not appear
        i_sarc_analog_model.level[4'h9] = 10'h0F0;
        wr_reg(A_CSR, 32'h00000029);
        repeat (20) @(posedge clk_sys);
        conv(4'hA, 1'b0, 2'h0, 10'h30C);
        // Let further conversions overwrite without reading
        wait_eoc();
        i_sarc_analog_model.level[4'hA] = 10'h1E7;
        repeat (200) @(posedge clk_sys);
        rd_reg(A_LOW, 32'h3, 32'hFFFFFFFF);
        rd_reg(A_HIGH, 32'h79, 32'hFFFFFFFF);
        $display("test restart and overwrite done");
        halt_mode <= 1'b1;
        wr_reg(A_CSR, 32'h0000002A);
        repeat (200) @(posedge clk_sys);
        rd_reg(A_CSR, 32'h0000002A, 32'hFFFFFFFF);
        halt_mode <= 1'b0;
        repeat (20) @(posedge clk_sys);
        wait_eoc();
        wr_reg(A_CSR, 32'h00000000);
        repeat (200) @(posedge clk_sys);
        rd_reg(A_CSR, 32'h0, 32'hFFFFFFFF);
        $display("test power modes done");
        wrap_up();
    end
endmodule : sarc_top_bench
